// file: dv/scc_cmd_assertions.sv
// concurrent checks on the command/control block ports
// assumes bind into scc_cmd; channel A bits only, channel B logic is the same
`timescale 1ns/1ns
`default_nettype none
module scc_cmd_assertions (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // host port
  input wire logic HOST_WR,
  input wire logic HOST_CD,
  input wire logic HOST_BA,
  // channel inputs
  input wire logic [1:0] RX_PAR_ERR,
  input wire logic [1:0] SDLC_MODE,
  // observed outputs
  input wire logic [1:0] ABORT_REQ,
  input wire logic [1:0] CHAN_RST,
  input wire logic [1:0] CHK_TX_RST,
  input wire logic [1:0] CHK_FILL,
  input wire logic [1:0] EXT_LATCHED,
  input wire logic [1:0] PAR_ERR,
  input wire logic CFG_WE,
  input wire logic CFG_CH,
  input wire logic [2:0] CFG_PTR,
  input wire logic [1:0] PACE_O,
  input wire logic [1:0] PACE_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // ************************************************
  // properties
  // ************************************************
  a_abort_sdlc_only: assert property (ABORT_REQ[0] |-> $past(SDLC_MODE[0]))
    else $error("abort without bit framing");
  a_chan_rst_gap: assert property (CHAN_RST[0] |=> !CHAN_RST[0] [*4])
    else $error("channel reset inside reset gap");
  a_fill_follows_mode: assert property (CHK_TX_RST[0] |-> CHK_FILL[0] == $past(SDLC_MODE[0]))
    else $error("checksum preset wrong");
  a_par_latch_set: assert property (RX_PAR_ERR[0] |=> PAR_ERR[0])
    else $error("parity error not latched");
  // a latch may only drop after a command write or a reset
  a_par_latch_hold: assert property ($fell(PAR_ERR[0]) |->
    $past(SYS_RST) || $past(HOST_WR && HOST_CD && !HOST_BA))
    else $error("parity latch dropped by itself");
  a_ext_latch_hold: assert property ($fell(EXT_LATCHED[0]) |->
    $past(SYS_RST) || $past(HOST_WR && HOST_CD && !HOST_BA))
    else $error("status latch dropped by itself");
  a_cfg_ptr_range: assert property (CFG_WE |-> $past(HOST_WR && HOST_CD) && CFG_PTR > 3'h1)
    else $error("config write with bad pointer");
  a_cfg_channel: assert property (CFG_WE |-> CFG_CH == $past(HOST_BA))
    else $error("config write on wrong channel");
  // a released wait pin may only ever pull low, never claim a high level
  a_wait_open_drain: assert property (!PACE_OE[0] && !$past(SYS_RST) |-> !PACE_O[0])
    else $error("pacing pin drive wrong");
endmodule // scc_cmd_assertions
bind scc_cmd scc_cmd_assertions chk (.SYS_CLK, .SYS_RST, .HOST_WR, .HOST_CD, .HOST_BA,
  .RX_PAR_ERR, .SDLC_MODE, .ABORT_REQ, .CHAN_RST, .CHK_TX_RST, .CHK_FILL, .EXT_LATCHED,
  .PAR_ERR, .CFG_WE, .CFG_CH, .CFG_PTR, .PACE_O, .PACE_OE);
`default_nettype wire

// file: dv/scc_cmd_tb.sv
// self-checking bench for the command/control block
// assumes the host model drives the register port; events are driven here
`timescale 1ns/1ns
`default_nettype none
module scc_cmd_tb;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic HOST_WR, HOST_RD, HOST_CD, HOST_BA, INT_ACK = 1'b0, RETURN_SEEN = 1'b0;
  logic [7:0] HOST_WDATA, HOST_RDATA, VECTOR, CFG_DATA, d;
  logic [1:0] EXT_CHANGE = 2'h0, TX_EMPTY = 2'h0, TX_LOAD = 2'h0, CHK_DONE = 2'h0;
  logic [1:0] RX_CHAR = 2'h0, RX_PAR_ERR = 2'h0, RX_OVR_ERR = 2'h0, RX_SPECIAL = 2'h0;
  logic [1:0] SDLC_MODE = 2'h3, RX_FULL = 2'h0, TX_FULL = 2'h0;
  logic [1:0] ABORT_REQ, CHAN_RST, CHK_RX_RST, CHK_TX_RST, CHK_FILL, EOM_RST;
  logic [1:0] EXT_LATCHED, PAR_ERR, OVR_ERR, PACE_O, PACE_OE;
  logic INT_REQ, CFG_WE, CFG_CH;
  logic [2:0] CFG_PTR;
  int fails = 0, comparisons = 0, cycles = 0, i;
  initial
  begin
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  scc_host h (.clk(SYS_CLK), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_CD(HOST_CD),
    .HOST_BA(HOST_BA), .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA));
  scc_cmd dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD),
    .HOST_CD(HOST_CD), .HOST_BA(HOST_BA), .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA),
    .EXT_CHANGE(EXT_CHANGE), .TX_EMPTY(TX_EMPTY), .TX_LOAD(TX_LOAD), .CHK_DONE(CHK_DONE),
    .RX_CHAR(RX_CHAR), .RX_PAR_ERR(RX_PAR_ERR), .RX_OVR_ERR(RX_OVR_ERR),
    .RX_SPECIAL(RX_SPECIAL), .SDLC_MODE(SDLC_MODE), .RX_FULL(RX_FULL), .TX_FULL(TX_FULL),
    .INT_ACK(INT_ACK), .RETURN_SEEN(RETURN_SEEN), .INT_REQ(INT_REQ), .VECTOR(VECTOR),
    .ABORT_REQ(ABORT_REQ), .CHAN_RST(CHAN_RST), .CHK_RX_RST(CHK_RX_RST),
    .CHK_TX_RST(CHK_TX_RST), .CHK_FILL(CHK_FILL), .EOM_RST(EOM_RST),
    .EXT_LATCHED(EXT_LATCHED), .PAR_ERR(PAR_ERR), .OVR_ERR(OVR_ERR), .CFG_WE(CFG_WE),
    .CFG_CH(CFG_CH), .CFG_PTR(CFG_PTR), .CFG_DATA(CFG_DATA), .PACE_O(PACE_O),
    .PACE_OE(PACE_OE));
  // ************************************************
  // helpers
  // ************************************************
  task check(input logic [15:0] seen, input logic [15:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task tick(input int n);
  begin
    repeat (n) @(negedge SYS_CLK);
  end
  endtask
  // one-cycle event pulse, then wait out the pending and request flops
  task automatic pulse(ref logic [1:0] sig, input logic [1:0] v);
  begin
    sig = v;
    @(negedge SYS_CLK);
    sig = 2'h0;
    tick(2);
  end
  endtask
  task tally_and_finish;
  begin
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  always @(posedge SYS_CLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  // ************************************************
  // scenarios
  // ************************************************
  initial
  begin
    repeat (8) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    SYS_RST = 1'b0;
    for (i = 2; i < 8; i++)
    begin
      h.wr(1'b1, 1'b0, i[7:0]);
      h.wr(1'b1, 1'b0, 8'h40 + i[7:0]);
      check(CFG_WE, 8'h01);
      check(CFG_PTR, i[7:0]);
      check(CFG_DATA, 8'h40 + i[7:0]);
    end
    h.wr(1'b1, 1'b0, 8'h00);
    check(CFG_WE, 8'h00);
    h.wr(1'b1, 1'b0, 8'h08);
    check(ABORT_REQ, 8'h01);
    for (i = 1; i < 4; i++)
    begin
      h.wr(1'b1, 1'b0, i[1:0] << 6);
      check({EOM_RST[0], CHK_TX_RST[0], CHK_RX_RST[0]}, 8'h01 << (i - 1));
      check(CHK_FILL[0], 8'h01);
    end
    SDLC_MODE = 2'h0;
    h.wr(1'b1, 1'b0, 8'h88);
    check({ABORT_REQ, CHK_TX_RST}, 8'h01);
    check(CHK_FILL, 8'h00);
    SDLC_MODE = 2'h3;
    RX_OVR_ERR = 2'h1;
    pulse(RX_PAR_ERR, 2'h1);
    RX_OVR_ERR = 2'h0;
    h.wr(1'b1, 1'b0, 8'h01);
    h.rd(1'b1, 1'b0, d);
    check(d, 8'h30);
    h.wr(1'b1, 1'b0, 8'h30);
    check(PAR_ERR, 8'h00);
    check(OVR_ERR, 8'h00);
    h.wr(1'b1, 1'b1, 8'h02);
    h.wr(1'b1, 1'b1, 8'h80);
    h.wr(1'b1, 1'b1, 8'h01);
    h.wr(1'b1, 1'b1, 8'h06);
    h.wr(1'b1, 1'b0, 8'h01);
    h.wr(1'b1, 1'b0, 8'h13);
    pulse(EXT_CHANGE, 2'h1);
    check(EXT_LATCHED, 8'h01);
    check({INT_REQ, VECTOR}, 9'h18a);
    h.wr(1'b1, 1'b0, 8'h10);
    tick(1);
    check({EXT_LATCHED, INT_REQ}, 8'h00);
    pulse(TX_EMPTY, 2'h1);
    check({INT_REQ, VECTOR}, 9'h188);
    h.wr(1'b1, 1'b0, 8'h28);
    tick(1);
    check(INT_REQ, 8'h00);
    pulse(RX_CHAR, 2'h1);
    check({INT_REQ, VECTOR}, 9'h18c);
    INT_ACK = 1'b1;
    @(posedge SYS_CLK);
    INT_ACK <= 1'b0;
    @(negedge SYS_CLK);
    h.rd(1'b0, 1'b0, d);
    pulse(TX_EMPTY, 2'h2);
    check(INT_REQ, 8'h00);
    h.wr(1'b1, 1'b0, 8'h38);
    tick(1);
    check({INT_REQ, VECTOR}, 9'h180);
    h.wr(1'b1, 1'b0, 8'h18);
    check(CHAN_RST, 8'h01);
    h.wr(1'b1, 1'b0, 8'h02);
    tick(4);
    h.wr(1'b1, 1'b0, 8'h02);
    check(CFG_WE, 8'h00);
    h.wr(1'b1, 1'b0, 8'h77);
    check(CFG_DATA, 8'h77);
    h.wr(1'b1, 1'b0, 8'h01);
    h.wr(1'b1, 1'b0, 8'he0);
    RX_FULL = 2'h1;
    tick(2);
    check({PACE_OE[0], PACE_O[0]}, 8'h02);
    h.wr(1'b1, 1'b0, 8'h01);
    h.wr(1'b1, 1'b0, 8'h60);
    tick(1);
    check(PACE_O[0], 8'h01);
    RX_FULL = 2'h0;
    h.wr(1'b1, 1'b0, 8'h01);
    h.wr(1'b1, 1'b0, 8'ha0);
    h.rd(1'b0, 1'b0, d);
    check({PACE_OE[0], PACE_O[0]}, 8'h02);
    // first-character mode: one interrupt per arm
    h.wr(1'b1, 1'b0, 8'h01);
    h.wr(1'b1, 1'b0, 8'h08);
    pulse(RX_CHAR, 2'h1);
    check({INT_REQ, VECTOR}, 9'h18c);
    h.rd(1'b0, 1'b0, d);
    pulse(RX_CHAR, 2'h1);
    check({INT_REQ, VECTOR}, 9'h180);
    h.wr(1'b1, 1'b0, 8'h20);
    pulse(RX_CHAR, 2'h1);
    check({INT_REQ, VECTOR}, 9'h18c);
    h.wr(1'b1, 1'b1, 8'h01);
    h.wr(1'b1, 1'b1, 8'h00);
    tick(1);
    check(VECTOR, 8'h80);
    INT_ACK = 1'b1;
    @(posedge SYS_CLK);
    INT_ACK <= 1'b0;
    tick(2);
    check(INT_REQ, 8'h00);
    RETURN_SEEN = 1'b1;
    @(posedge SYS_CLK);
    RETURN_SEEN <= 1'b0;
    tick(2);
    check(INT_REQ, 8'h01);
    tally_and_finish;
  end
endmodule // scc_cmd_tb
`default_nettype wire

// file: dv/scc_host.sv
// host processor model on the parallel command/data port
// assumes tasks are entered at a falling edge; they return at a falling edge
`timescale 1ns/1ns
`default_nettype none
module scc_host (
  // clock
  input wire logic clk,
  // host port
  output logic HOST_WR,
  output logic HOST_RD,
  output logic HOST_CD,
  output logic HOST_BA,
  output logic [7:0] HOST_WDATA,
  input wire logic [7:0] HOST_RDATA
);
  initial
  begin
    HOST_WR = 1'b0;
    HOST_RD = 1'b0;
    HOST_CD = 1'b0;
    HOST_BA = 1'b0;
    HOST_WDATA = 8'h00;
  end
  // released data shows the inverse so a stale byte never looks valid
  task wr(input logic cd, input logic ba, input logic [7:0] d);
  begin
    HOST_CD = cd;
    HOST_BA = ba;
    HOST_WDATA = d;
    HOST_WR = 1'b1;
    @(posedge clk);
    HOST_WR <= 1'b0;
    HOST_WDATA <= ~d;
    @(negedge clk);
  end
  endtask
  task rd(input logic cd, input logic ba, output logic [7:0] d);
  begin
    HOST_CD = cd;
    HOST_BA = ba;
    HOST_RD = 1'b1;
    @(posedge clk);
    HOST_RD <= 1'b0;
    @(negedge clk);
    d = HOST_RDATA;
  end
  endtask
endmodule // scc_host
`default_nettype wire

// file: hw/scc_cmd.v
// command/pointer and interrupt/pacing control for a two-channel serial controller
// assumes host strobes are one-cycle pulses synchronous to SYS_CLK
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.vh"

module scc_cmd (
  // clock and reset
  input wire SYS_CLK,
  input wire SYS_RST,
  // host port
  input wire HOST_WR,
  input wire HOST_RD,
  input wire HOST_CD,
  input wire HOST_BA,
  input wire [7:0] HOST_WDATA,
  output wire [7:0] HOST_RDATA,
  // channel events, bit0 channel a
  input wire [1:0] EXT_CHANGE,
  input wire [1:0] TX_EMPTY,
  input wire [1:0] TX_LOAD,
  input wire [1:0] CHK_DONE,
  input wire [1:0] RX_CHAR,
  input wire [1:0] RX_PAR_ERR,
  input wire [1:0] RX_OVR_ERR,
  input wire [1:0] RX_SPECIAL,
  input wire [1:0] SDLC_MODE,
  input wire [1:0] RX_FULL,
  input wire [1:0] TX_FULL,
  // interrupt handshake
  input wire INT_ACK,
  input wire RETURN_SEEN,
  output wire INT_REQ,
  output wire [7:0] VECTOR,
  // commands to datapath
  output wire [1:0] ABORT_REQ,
  output wire [1:0] CHAN_RST,
  output wire [1:0] CHK_RX_RST,
  output wire [1:0] CHK_TX_RST,
  output wire [1:0] CHK_FILL,
  output wire [1:0] EOM_RST,
  output wire [1:0] EXT_LATCHED,
  output wire [1:0] PAR_ERR,
  output wire [1:0] OVR_ERR,
  // other write registers
  output wire CFG_WE,
  output wire CFG_CH,
  output wire [2:0] CFG_PTR,
  output wire [7:0] CFG_DATA,
  // pacing pins
  output wire [1:0] PACE_O,
  output wire [1:0] PACE_OE
);

  // ************************************************
  // decode helpers
  // ************************************************
  function cmd_is;
    input [7:0] d;
    input [2:0] code;
    begin
      cmd_is = (d[`SCC_F_CMD] == code);
    end
  endfunction

  function chk_is;
    input [7:0] d;
    input [1:0] code;
    begin
      chk_is = (d[`SCC_F_CHK] == code);
    end
  endfunction

  // ************************************************
  // state
  // ************************************************
  reg [2:0] ptr_q [0:1];
  reg [7:0] ipc_q [0:1];
  reg [2:0] gap_q [0:1];
  reg [7:0] vreg_q;
  reg [1:0] ext_lat_q;
  reg [1:0] ext_pend_q;
  reg [1:0] tx_pend_q;
  reg [1:0] tx_inh_q;
  reg [1:0] rx_pend_q;
  reg [1:0] sp_pend_q;
  reg [1:0] arm_q;
  reg [1:0] par_q;
  reg [1:0] ovr_q;
  reg [1:0] svc_q;
  reg [7:0] rdata_q;
  reg int_q;
  reg [7:0] vec_q;
  reg [1:0] abort_q;
  reg [1:0] chrst_q;
  reg [1:0] chkrx_q;
  reg [1:0] chktx_q;
  reg [1:0] fill_q;
  reg [1:0] eom_q;
  reg cfg_we_q;
  reg cfg_ch_q;
  reg [2:0] cfg_ptr_q;
  reg [7:0] cfg_data_q;
  reg [1:0] pace_q;
  reg [1:0] pace_oe_q;
  integer i;

  // ************************************************
  // access decode
  // ************************************************
  wire [1:0] ch_sel = {HOST_BA, ~HOST_BA};
  wire [1:0] busy = {gap_q[1] != 3'h0, gap_q[0] != 3'h0};
  // writes during the recovery gap are dropped rather than half-applied
  wire [1:0] ctl_wr = {2{HOST_WR & HOST_CD}} & ch_sel & ~busy;
  wire [1:0] ctl_rd = {2{HOST_RD & HOST_CD}} & ch_sel;
  wire [1:0] dat_rd = {2{HOST_RD & ~HOST_CD}} & ch_sel;
  wire [1:0] dat_acc = {2{(HOST_RD | HOST_WR) & ~HOST_CD}} & ch_sel;
  wire any_acc = HOST_RD | HOST_WR;
  wire [1:0] at_cmd = {ptr_q[1] == `SCC_REG_CMD, ptr_q[0] == `SCC_REG_CMD};
  wire [1:0] c0_wr = ctl_wr & at_cmd;
  wire [1:0] rg_wr = ctl_wr & ~at_cmd;
  wire [1:0] rg_acc = (ctl_wr | ctl_rd) & ~at_cmd;

  // ************************************************
  // command strobes
  // ************************************************
  wire [1:0] do_abort = c0_wr & {2{cmd_is(HOST_WDATA, `SCC_CMD_ABORT)}};
  wire [1:0] do_ext = c0_wr & {2{cmd_is(HOST_WDATA, `SCC_CMD_EXT_RST)}};
  wire [1:0] do_rst = c0_wr & {2{cmd_is(HOST_WDATA, `SCC_CMD_CH_RST)}};
  wire [1:0] do_arm = c0_wr & {2{cmd_is(HOST_WDATA, `SCC_CMD_RX_ARM)}};
  wire [1:0] do_txc = c0_wr & {2{cmd_is(HOST_WDATA, `SCC_CMD_TX_CLR)}};
  wire [1:0] do_err = c0_wr & {2{cmd_is(HOST_WDATA, `SCC_CMD_ERR_RST)}};
  wire do_ret = c0_wr[0] & cmd_is(HOST_WDATA, `SCC_CMD_RETURN);
  wire [1:0] do_crx = c0_wr & {2{chk_is(HOST_WDATA, `SCC_CHK_RX)}};
  wire [1:0] do_ctx = c0_wr & {2{chk_is(HOST_WDATA, `SCC_CHK_TX)}};
  wire [1:0] do_eom = c0_wr & {2{chk_is(HOST_WDATA, `SCC_CHK_EOM)}};

  // ************************************************
  // interrupt cause qualification
  // ************************************************
  wire [1:0] rxm0 = {ipc_q[1][3], ipc_q[0][3]};
  wire [1:0] rxm1 = {ipc_q[1][4], ipc_q[0][4]};
  wire [1:0] rx_on = rxm0 | rxm1;
  wire [1:0] m_first = rxm0 & ~rxm1;
  wire [1:0] m_all = rxm1;
  wire [1:0] par_sp = rx_on & ~(rxm0 & rxm1);
  wire [1:0] ext_ie = {ipc_q[1][`SCC_B_EXT_IE], ipc_q[0][`SCC_B_EXT_IE]};
  wire [1:0] tx_ie = {ipc_q[1][`SCC_B_TX_IE], ipc_q[0][`SCC_B_TX_IE]};
  wire [1:0] ext_set = EXT_CHANGE & ext_ie & ~ext_lat_q;
  wire [1:0] tx_set = TX_EMPTY & tx_ie & ~tx_inh_q;
  wire [1:0] rx_set = RX_CHAR & (m_all | (m_first & arm_q));
  wire [1:0] sp_ev = RX_OVR_ERR | RX_SPECIAL | (RX_PAR_ERR & par_sp);
  wire [1:0] sp_set = sp_ev & rx_on;
  wire [3:0] pa = {sp_pend_q[0], rx_pend_q[0], tx_pend_q[0], ext_pend_q[0]};
  wire [3:0] pb = {sp_pend_q[1], rx_pend_q[1], tx_pend_q[1], ext_pend_q[1]};
  wire hit_a;
  wire [7:0] vec_d;
  // a higher channel may nest over a lower one in service, never the reverse
  wire int_d = ((|pa) & ~svc_q[0]) | ((|pb) & ~(|svc_q));

  scc_vec u_vec (
    .pend_a(pa),
    .pend_b(pb),
    .base(vreg_q),
    .sav(ipc_q[1][`SCC_B_SAV]),
    .hit_a(hit_a),
    .vec(vec_d)
  );

  // ************************************************
  // pacing
  // ************************************************
  wire [1:0] pace_d;
  wire [1:0] pace_oe_d;

  scc_pace u_pace_a (
    .en(ipc_q[0][`SCC_B_PEN]),
    .fn_ready(ipc_q[0][`SCC_B_PFN]),
    .dir_rx(ipc_q[0][`SCC_B_PDIR]),
    .rx_full(RX_FULL[0]),
    .tx_full(TX_FULL[0]),
    .data_sel(dat_acc[0]),
    .any_acc(any_acc),
    .lvl(pace_d[0]),
    .oe(pace_oe_d[0])
  );

  scc_pace u_pace_b (
    .en(ipc_q[1][`SCC_B_PEN]),
    .fn_ready(ipc_q[1][`SCC_B_PFN]),
    .dir_rx(ipc_q[1][`SCC_B_PDIR]),
    .rx_full(RX_FULL[1]),
    .tx_full(TX_FULL[1]),
    .data_sel(dat_acc[1]),
    .any_acc(any_acc),
    .lvl(pace_d[1]),
    .oe(pace_oe_d[1])
  );

  // ************************************************
  // readback
  // ************************************************
  reg [7:0] rd_d;
  reg [2:0] rd_ptr;

  always @*
  begin
    rd_ptr = HOST_BA ? ptr_q[1] : ptr_q[0];
    rd_d = 8'h00;
    if (rd_ptr == `SCC_REG_CMD)
    begin
      rd_d[`SCC_RB_RX] = rx_pend_q[HOST_BA];
      rd_d[`SCC_RB_INT] = ~HOST_BA & int_q;
      rd_d[`SCC_RB_TX] = tx_pend_q[HOST_BA];
      rd_d[`SCC_RB_EXT] = ext_lat_q[HOST_BA];
    end
    else if (rd_ptr == `SCC_REG_IPC)
    begin
      rd_d[`SCC_RB_PAR] = par_q[HOST_BA];
      rd_d[`SCC_RB_OVR] = ovr_q[HOST_BA];
    end
    else if (rd_ptr == `SCC_REG_VEC && HOST_BA)
      rd_d = vec_d;
  end

  // ************************************************
  // main sequential
  // ************************************************
  always @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        ptr_q[i] <= `SCC_REG_CMD;
        ipc_q[i] <= `SCC_RST_BYTE;
        gap_q[i] <= 3'h0;
      end
      vreg_q <= `SCC_RST_BYTE;
      ext_lat_q <= 2'h0;
      ext_pend_q <= 2'h0;
      tx_pend_q <= 2'h0;
      tx_inh_q <= 2'h0;
      rx_pend_q <= 2'h0;
      sp_pend_q <= 2'h0;
      arm_q <= 2'h3;
      par_q <= 2'h0;
      ovr_q <= 2'h0;
      svc_q <= 2'h0;
      rdata_q <= 8'h00;
      int_q <= 1'b0;
      vec_q <= `SCC_RST_BYTE;
      abort_q <= 2'h0;
      chrst_q <= 2'h0;
      chkrx_q <= 2'h0;
      chktx_q <= 2'h0;
      fill_q <= 2'h0;
      eom_q <= 2'h0;
      cfg_we_q <= 1'b0;
      cfg_ch_q <= 1'b0;
      cfg_ptr_q <= 3'h0;
      cfg_data_q <= 8'h00;
      pace_q <= 2'h3;
      pace_oe_q <= 2'h0;
    end
    else
    begin
      int_q <= int_d;
      vec_q <= vec_d;
      pace_q <= pace_d;
      pace_oe_q <= pace_oe_d;
      if (HOST_RD & HOST_CD)
        rdata_q <= rd_d;
      abort_q <= do_abort & SDLC_MODE;
      chrst_q <= do_rst;
      chkrx_q <= do_crx;
      chktx_q <= do_ctx;
      eom_q <= do_eom;
      cfg_we_q <= 1'b0;
      for (i = 0; i < 2; i = i + 1)
      begin
        if (do_crx[i] | do_ctx[i])
          fill_q[i] <= SDLC_MODE[i];
        if (gap_q[i] != 3'h0)
          gap_q[i] <= gap_q[i] - 3'h1;
        if (do_rst[i])
        begin
          // channel pointer, control and status flops back to reset; recovery gap starts
          ptr_q[i] <= `SCC_REG_CMD;
          ipc_q[i] <= `SCC_RST_BYTE;
          gap_q[i] <= `SCC_RST_GAP_CYC;
          ext_lat_q[i] <= 1'b0;
          ext_pend_q[i] <= 1'b0;
          tx_pend_q[i] <= 1'b0;
          tx_inh_q[i] <= 1'b0;
          rx_pend_q[i] <= 1'b0;
          sp_pend_q[i] <= 1'b0;
          arm_q[i] <= 1'b1;
          par_q[i] <= 1'b0;
          ovr_q[i] <= 1'b0;
        end
        else
        begin
          if (c0_wr[i])
            ptr_q[i] <= HOST_WDATA[`SCC_F_PTR];
          else if (rg_acc[i])
            ptr_q[i] <= `SCC_REG_CMD;
          if (rg_wr[i])
          begin
            if (ptr_q[i] == `SCC_REG_IPC)
              ipc_q[i] <= HOST_WDATA;
            else if (!(ptr_q[i] == `SCC_REG_VEC && i == 1))
            begin
              cfg_we_q <= 1'b1;
              cfg_ch_q <= i[0];
              cfg_ptr_q <= ptr_q[i];
              cfg_data_q <= HOST_WDATA;
            end
          end
          // sets win over clears, except tx_inh_q (TX_LOAD or CHK_DONE beats do_txc) and ext_lat_q/ext_pend_q, whose set is masked while latched so do_ext wins
          ext_lat_q[i] <= (ext_lat_q[i] & ~do_ext[i]) | ext_set[i];
          ext_pend_q[i] <= (ext_pend_q[i] & ~do_ext[i]) | ext_set[i];
          tx_inh_q[i] <= (tx_inh_q[i] | do_txc[i]) & ~(TX_LOAD[i] | CHK_DONE[i]);
          tx_pend_q[i] <= (tx_pend_q[i] & ~do_txc[i] & ~TX_LOAD[i]) | tx_set[i];
          rx_pend_q[i] <= (rx_pend_q[i] & ~dat_rd[i]) | rx_set[i];
          sp_pend_q[i] <= (sp_pend_q[i] & ~do_err[i]) | sp_set[i];
          par_q[i] <= (par_q[i] & ~do_err[i]) | RX_PAR_ERR[i];
          ovr_q[i] <= (ovr_q[i] & ~do_err[i]) | RX_OVR_ERR[i];
          if (do_arm[i])
            arm_q[i] <= 1'b1;
          else if (RX_CHAR[i] & m_first[i])
            arm_q[i] <= 1'b0;
        end
      end
      // only channel b keeps the vector base; a's copy goes out on the cfg port
      if (rg_wr[1] && ptr_q[1] == `SCC_REG_VEC)
        vreg_q <= HOST_WDATA;
      // under-service latches
      if (do_rst[0])
        svc_q <= 2'h0;
      else if (INT_ACK && int_q)
        svc_q <= svc_q | (hit_a ? 2'h1 : 2'h2);
      else if (do_ret | RETURN_SEEN)
        svc_q <= svc_q[0] ? {svc_q[1], 1'b0} : 2'h0;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign HOST_RDATA = rdata_q;
  assign INT_REQ = int_q;
  assign VECTOR = vec_q;
  assign ABORT_REQ = abort_q;
  assign CHAN_RST = chrst_q;
  assign CHK_RX_RST = chkrx_q;
  assign CHK_TX_RST = chktx_q;
  assign CHK_FILL = fill_q;
  assign EOM_RST = eom_q;
  assign EXT_LATCHED = ext_lat_q;
  assign PAR_ERR = par_q;
  assign OVR_ERR = ovr_q;
  assign CFG_WE = cfg_we_q;
  assign CFG_CH = cfg_ch_q;
  assign CFG_PTR = cfg_ptr_q;
  assign CFG_DATA = cfg_data_q;
  assign PACE_O = pace_q;
  assign PACE_OE = pace_oe_q;

endmodule // scc_cmd

`default_nettype wire

// file: hw/scc_pace.v
// wait/ready pacing decode for one channel
// assumes buffer levels and access strobes are synchronous to the clock
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.vh"

module scc_pace (
  // control bits
  input wire en,
  input wire fn_ready,
  input wire dir_rx,
  // buffer state
  input wire rx_full,
  input wire tx_full,
  // bus activity
  input wire data_sel,
  input wire any_acc,
  // pin drive
  output reg lvl,
  output reg oe
);

  reg ready;
  reg waiting;

  always @*
  begin
    // one direction at a time, chosen by a single bit
    ready = dir_rx ? rx_full : ~tx_full;
    waiting = dir_rx ? ~rx_full : tx_full;
    if (fn_ready)
    begin
      // any bus transfer drops ready so the dma side re-arbitrates
      oe = 1'b1;
      lvl = ~(en & ready & ~any_acc);
    end
    else
    begin
      // open drain: driven only while pulling low
      oe = en & data_sel & waiting;
      lvl = 1'b0;
    end
  end

endmodule // scc_pace

`default_nettype wire

// file: hw/scc_vec.v
// interrupt source selection and vector build for both channels
// assumes pending causes are held in flops by the caller
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.vh"

module scc_vec (
  // pending causes, bit3 special, bit2 rx, bit1 tx, bit0 ext
  input wire [3:0] pend_a,
  input wire [3:0] pend_b,
  // vector control
  input wire [7:0] base,
  input wire sav,
  // result
  output wire hit_a,
  output wire [7:0] vec
);

  // cause code: 00 tx, 01 ext, 10 rx, 11 special
  function [1:0] cause;
    input [3:0] p;
    begin
      if (p[3])
        cause = 2'h3;
      else if (p[2])
        cause = 2'h2;
      else if (p[1])
        cause = 2'h0;
      else
        cause = 2'h1;
    end
  endfunction

  wire [1:0] code;

  // channel a outranks channel b
  assign hit_a = |pend_a;
  assign code = hit_a ? cause(pend_a) : cause(pend_b);
  assign vec = sav ? {base[7:4], hit_a, code, base[0]} : base;

endmodule // scc_vec

`default_nettype wire

// file: inc/scc_map.vh
// constants for the two-channel serial command/control block
// assumes includers use the macro names only; no logic lives here
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// ************************************************
// command/pointer byte fields
// ************************************************
`define SCC_F_PTR 2:0
`define SCC_F_CMD 5:3
`define SCC_F_CHK 7:6

// ************************************************
// register indices
// ************************************************
`define SCC_REG_CMD 3'h0
`define SCC_REG_IPC 3'h1
`define SCC_REG_VEC 3'h2

// ************************************************
// basic command codes
// ************************************************
`define SCC_CMD_NULL 3'h0
`define SCC_CMD_ABORT 3'h1
`define SCC_CMD_EXT_RST 3'h2
`define SCC_CMD_CH_RST 3'h3
`define SCC_CMD_RX_ARM 3'h4
`define SCC_CMD_TX_CLR 3'h5
`define SCC_CMD_ERR_RST 3'h6
`define SCC_CMD_RETURN 3'h7

// ************************************************
// checksum reset codes
// ************************************************
`define SCC_CHK_NULL 2'h0
`define SCC_CHK_RX 2'h1
`define SCC_CHK_TX 2'h2
`define SCC_CHK_EOM 2'h3

// ************************************************
// interrupt/pacing control bits
// ************************************************
`define SCC_B_EXT_IE 0
`define SCC_B_TX_IE 1
`define SCC_B_SAV 2
`define SCC_F_RXM 4:3
`define SCC_B_PDIR 5
`define SCC_B_PFN 6
`define SCC_B_PEN 7

// ************************************************
// receive interrupt modes
// ************************************************
`define SCC_RXM_OFF 2'h0
`define SCC_RXM_FIRST 2'h1
`define SCC_RXM_ALL_PAR 2'h2
`define SCC_RXM_ALL 2'h3

// ************************************************
// readback bit positions
// ************************************************
`define SCC_RB_RX 0
`define SCC_RB_INT 1
`define SCC_RB_TX 2
`define SCC_RB_EXT 3
`define SCC_RB_PAR 4
`define SCC_RB_OVR 5

// ************************************************
// reset values and timing
// ************************************************
`define SCC_RST_BYTE 8'h00
`define SCC_RST_GAP_CYC 3'h4

`endif
